/* File: design/nvm_pkg.sv */
// Purpose: Shared constants and types for the nonvolatile memory access unit.
// Assumes: Byte-wide register port with a 3-bit register index.
// Notes:   Offsets of the control and key registers are local choices.
package nvm_pkg;

    // Register indexes on the plain register port.
    localparam logic [2:0] NVM_OFS_DATA_LOW     = 3'h0;
    localparam logic [2:0] NVM_OFS_DATA_HIGH    = 3'h1;
    localparam logic [2:0] NVM_OFS_ADDRESS_LOW  = 3'h2;
    localparam logic [2:0] NVM_OFS_ADDRESS_HIGH = 3'h3;
    localparam logic [2:0] NVM_OFS_CONTROL      = 3'h4;
    localparam logic [2:0] NVM_OFS_UNLOCK_KEY   = 3'h5;
    localparam logic [2:0] NVM_OFS_PROTECT      = 3'h6;

    // Control register bit positions.
    localparam int NVM_CTL_WRITE_START   = 1;
    localparam int NVM_CTL_WRITE_ENABLE  = 2;
    localparam int NVM_CTL_LATCH_ONLY    = 5;
    localparam int NVM_CTL_CONFIG_SPACE  = 6;
    localparam int NVM_CTL_MEMORY_SELECT = 7;
    // Protection register bit positions (zero means protected).
    localparam int NVM_PROT_PROGRAM = 0;
    localparam int NVM_PROT_DATA    = 1;

    // Reset values.
    localparam logic [7:0] NVM_ADDRESS_LOW_RST  = 8'h00;
    localparam logic [6:0] NVM_ADDRESS_HIGH_RST = 7'h00;
    localparam logic [7:0] NVM_CONTROL_RST      = 8'h00;
    localparam logic [1:0] NVM_PROTECT_RST      = 2'h3;

    // Unlock keys and row geometry.
    localparam logic [7:0] NVM_KEY_FIRST  = 8'h55;
    localparam logic [7:0] NVM_KEY_SECOND = 8'hAA;
    localparam logic [2:0] NVM_ROW_LAST   = 3'h7;
    localparam int         NVM_ROW_WORDS  = 8;

    // Instructions swallowed after write-start before execution resumes.
    localparam logic [1:0] NVM_SKIP_COUNT = 2'h2;

    // Unlock progress.
    typedef enum logic [1:0] {
        NVM_KEY_IDLE,
        NVM_KEY_GOT_FIRST,
        NVM_KEY_ARMED
    } nvm_key_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        NVM_ST_IDLE,
        NVM_ST_LATCH,
        NVM_ST_PROGRAM,
        NVM_ST_ERASE,
        NVM_ST_WAIT
    } nvm_state_t;

endpackage : nvm_pkg

/* File: design/nvm_array_if.sv */
// Purpose: Carries array commands from the sequencer to the array driver.
// Assumes: Single clock; commands are one-cycle pulses.
// Notes:   The driver answers with a one-cycle done pulse.
`timescale 1ns/10ps
interface nvm_array_if;
    logic        go;
    logic        erase;
    logic        program_space;
    logic [14:0] address;
    logic        done;
    logic        busy;

    modport sequencer (output go, output erase, output program_space, output address,
                       input done, input busy);
    modport driver    (input go, input erase, input program_space, input address,
                       output done, output busy);
endinterface : nvm_array_if

/* File: design/nvm_array_drv.sv */
// Purpose: Hands one array operation to the flash or EEPROM and reports its end.
// Assumes: The array raises its ready input when self-timed work completes.
// Notes:   Outputs are registered.
`timescale 1ns/10ps
module nvm_array_drv
    import nvm_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    nvm_array_if.driver cmd,
    input  wire logic   array_ready,
    output logic        array_start,
    output logic        array_erase,
    output logic        array_program_space
);
    logic busy_r;
    logic done_r;

    // Starts an operation on request and waits for the array to finish.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_r              <= 1'b0;
            done_r              <= 1'b0;
            array_start         <= 1'b0;
            array_erase         <= 1'b0;
            array_program_space <= 1'b0;
        end else begin
            array_start <= cmd.go && !busy_r;
            done_r      <= busy_r && !array_start && array_ready;
            if (cmd.go && !busy_r) begin
                busy_r              <= 1'b1;
                array_erase         <= cmd.erase;
                array_program_space <= cmd.program_space;
            end else if (busy_r && !array_start && array_ready) begin
                busy_r <= 1'b0;
            end
        end
    end

    assign cmd.done = done_r;
    assign cmd.busy = busy_r;

endmodule : nvm_array_drv

/* File: design/nvm_row_write_access.sv */
// Purpose: Register file and write sequencer for program flash and data EEPROM.
// Assumes: Register port strobes are one cycle; instr_step pulses per instruction.
// Notes:   The core is held through cpu_stall_r while an array write runs.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps

// Functional notes
// - Row is eight words; last latch at 0x07.
// - Memory select set targets program flash.
// - Config select clear targets normal space.
// - Latch-only set with memory select set just loads the write latch.
// - Latch-only clear with memory select set loads then programs whole row.
// - Write-start honoured only after 55h then AAh.
// - Ignore next two instructions and halt during write.
// - Resume at third instruction after write-start.
// - Data low is eight bits read/write.
// - Data high holds bits 13:8; bits 7:6 read zero.
// - Address low is eight bits, reset zero.
// - Address high bits 14:8; bit 7 reads one.
module nvm_row_write_access
    import nvm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    input  wire logic        instr_step,
    output logic             cpu_stall_r,
    output logic             instr_squash_r,
    output logic             latch_load_r,
    output logic      [2:0]  latch_index_r,
    output logic      [13:0] latch_word_r,
    output logic      [14:0] array_address_r,
    output logic             array_config_space_r,
    input  wire logic        array_ready,
    output logic             array_start,
    output logic             array_erase,
    output logic             array_program_space
);

    // Holding registers and control state.
    logic [7:0]  data_low_r;
    logic [5:0]  data_high_r;
    logic [7:0]  address_low_r;
    logic [6:0]  address_high_r;
    logic [7:0]  control_r;
    logic [1:0]  protect_r;
    logic [1:0]  skip_cnt_r;
    logic        erase_prog_r;
    nvm_key_t    key_r;
    nvm_key_t    key_nxt;
    nvm_state_t  state_r;
    nvm_state_t  state_nxt;

    nvm_array_if arr ();

    nvm_array_drv u_drv (
        .sys_clk             (sys_clk),
        .resetn              (resetn),
        .cmd                 (arr),
        .array_ready         (array_ready),
        .array_start         (array_start),
        .array_erase         (array_erase),
        .array_program_space (array_program_space)
    );

    // Register decode.
    wire wr_data_low  = reg_write && (reg_addr == NVM_OFS_DATA_LOW);
    wire wr_data_high = reg_write && (reg_addr == NVM_OFS_DATA_HIGH);
    wire wr_addr_low  = reg_write && (reg_addr == NVM_OFS_ADDRESS_LOW);
    wire wr_addr_high = reg_write && (reg_addr == NVM_OFS_ADDRESS_HIGH);
    wire wr_control   = reg_write && (reg_addr == NVM_OFS_CONTROL);
    wire wr_key       = reg_write && (reg_addr == NVM_OFS_UNLOCK_KEY);
    wire wr_protect   = reg_write && (reg_addr == NVM_OFS_PROTECT);

    // Control fields.
    wire write_enable  = control_r[NVM_CTL_WRITE_ENABLE];
    wire latch_only    = control_r[NVM_CTL_LATCH_ONLY];
    wire config_space  = control_r[NVM_CTL_CONFIG_SPACE];
    wire memory_select = control_r[NVM_CTL_MEMORY_SELECT];
    wire start_req     = wr_control && reg_wdata[NVM_CTL_WRITE_START];
    wire idle          = (state_r == NVM_ST_IDLE);

    // A start counts only when unlocked, write-enabled and idle.
    wire start_ok = start_req && (key_r == NVM_KEY_ARMED) && write_enable && idle;

    // Target selection for the array.
    wire [14:0] full_address = {address_high_r, address_low_r};
    wire        row_last     = (address_low_r[2:0] == NVM_ROW_LAST);
    wire        go_program   = memory_select && !latch_only;

    // Clearing a protect bit to one (unprotect) triggers a bulk erase.
    wire unprot_prog = wr_protect && !protect_r[NVM_PROT_PROGRAM]
                       && reg_wdata[NVM_PROT_PROGRAM];
    wire unprot_data = wr_protect && !protect_r[NVM_PROT_DATA]
                       && reg_wdata[NVM_PROT_DATA];

    // Unlock key tracker: any other write between keys breaks the sequence.
    always_comb begin
        key_nxt = key_r;
        if (wr_key && reg_wdata == NVM_KEY_FIRST) begin
            key_nxt = NVM_KEY_GOT_FIRST;
        end else if (wr_key && key_r == NVM_KEY_GOT_FIRST && reg_wdata == NVM_KEY_SECOND) begin
            key_nxt = NVM_KEY_ARMED;
        end else if (reg_write) begin
            key_nxt = NVM_KEY_IDLE;
        end
    end

    // Sequencer next state.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            NVM_ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = go_program ? NVM_ST_PROGRAM : NVM_ST_LATCH;
                end else if ((unprot_prog || unprot_data) && !arr.busy) begin
                    state_nxt = NVM_ST_ERASE;
                end
            end
            NVM_ST_LATCH:   state_nxt = NVM_ST_WAIT;
            NVM_ST_PROGRAM: state_nxt = NVM_ST_WAIT;
            NVM_ST_ERASE:   state_nxt = NVM_ST_WAIT;
            NVM_ST_WAIT: begin
                if (arr.done || (skip_cnt_r == 2'h0 && !arr.busy && !cpu_stall_r)) begin
                    state_nxt = NVM_ST_IDLE;
                end
            end
            default: state_nxt = NVM_ST_IDLE;
        endcase
    end

    // Array command: program for a full row, erase on unprotect.
    // An erase goes to the space whose protection was just lifted, not to any open one.
    assign arr.go            = (state_r == NVM_ST_PROGRAM) || (state_r == NVM_ST_ERASE);
    assign arr.erase         = (state_r == NVM_ST_ERASE);
    assign arr.program_space = (state_r == NVM_ST_ERASE) ? erase_prog_r
                                                         : memory_select;
    assign arr.address       = full_address;

    // Holding registers.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            data_low_r     <= 8'h00;
            data_high_r    <= 6'h00;
            address_low_r  <= NVM_ADDRESS_LOW_RST;
            address_high_r <= NVM_ADDRESS_HIGH_RST;
        end else begin
            if (wr_data_low)  data_low_r     <= reg_wdata;
            if (wr_data_high) data_high_r    <= reg_wdata[5:0];
            if (wr_addr_low)  address_low_r  <= reg_wdata;
            if (wr_addr_high) address_high_r <= reg_wdata[6:0];
        end
    end

    // Control, protection, key and state registers.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            control_r <= NVM_CONTROL_RST;
            protect_r <= NVM_PROTECT_RST;
            key_r     <= NVM_KEY_IDLE;
            state_r   <= NVM_ST_IDLE;
            erase_prog_r <= 1'b0;
        end else begin
            key_r   <= start_req ? NVM_KEY_IDLE : key_nxt;
            state_r <= state_nxt;
            if (wr_protect) protect_r <= reg_wdata[1:0];
            // Program erase wins when both protections are lifted at once.
            if (idle) erase_prog_r <= unprot_prog;
            if (wr_control) begin
                control_r[7:2] <= reg_wdata[7:2];
                control_r[0]   <= reg_wdata[0];
            end
            // Start bit holds while busy and clears itself at the end.
            if (start_ok) begin
                control_r[NVM_CTL_WRITE_START] <= 1'b1;
            end else if (state_r == NVM_ST_WAIT && state_nxt == NVM_ST_IDLE) begin
                control_r[NVM_CTL_WRITE_START] <= 1'b0;
            end
        end
    end

    // Processor halt: squash the next two instructions, stall through the write.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_stall_r    <= 1'b0;
            instr_squash_r <= 1'b0;
            skip_cnt_r     <= 2'h0;
        end else begin
            if (start_ok) begin
                skip_cnt_r     <= NVM_SKIP_COUNT;
                instr_squash_r <= 1'b1;
                cpu_stall_r    <= go_program;
            end else begin
                if (instr_step && skip_cnt_r != 2'h0) begin
                    skip_cnt_r <= skip_cnt_r - 2'h1;
                end
                if (instr_step && skip_cnt_r == 2'h1) begin
                    instr_squash_r <= 1'b0;
                end
                if (arr.done) begin
                    cpu_stall_r <= 1'b0;
                end
            end
        end
    end

    // Latch load for every start in flash space.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            latch_load_r         <= 1'b0;
            latch_index_r        <= 3'h0;
            latch_word_r         <= 14'h0000;
            array_address_r      <= 15'h0000;
            array_config_space_r <= 1'b0;
        end else begin
            latch_load_r <= start_ok && memory_select;
            if (start_ok) begin
                latch_index_r        <= address_low_r[2:0];
                latch_word_r         <= {data_high_r, data_low_r};
                array_address_r      <= full_address;
                array_config_space_r <= config_space;
            end
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    logic [7:0] rd_mux;
    assign rd_mux = (reg_addr == NVM_OFS_DATA_LOW)     ? data_low_r :
                    (reg_addr == NVM_OFS_DATA_HIGH)    ? {2'b00, data_high_r} :
                    (reg_addr == NVM_OFS_ADDRESS_LOW)  ? address_low_r :
                    (reg_addr == NVM_OFS_ADDRESS_HIGH) ? {1'b1, address_high_r} :
                    (reg_addr == NVM_OFS_CONTROL)      ? control_r :
                    (reg_addr == NVM_OFS_PROTECT)      ? {6'h00, protect_r} :
                    8'h00;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? rd_mux : 8'h00;
        end
    end

    // Row geometry is fixed; the last-word flag is visible to software via address.
    wire unused_ok = row_last & (NVM_ROW_WORDS != 0);

endmodule : nvm_row_write_access

/* File: verification/nvm_rwa_asserts.sv */
// Purpose: Port-level checker for the row write unit.
// Assumes: One clock; register strobes last one cycle.
// Notes:   Shadows follow the key order and what software last wrote.
`timescale 1ns/10ps
module nvm_rwa_asserts
    import nvm_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [2:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    input wire logic        cpu_stall_r,
    input wire logic        instr_squash_r,
    input wire logic        latch_load_r,
    input wire logic [2:0]  latch_index_r,
    input wire logic [13:0] latch_word_r,
    input wire logic [14:0] array_address_r,
    input wire logic        array_ready,
    input wire logic        array_start,
    input wire logic        array_erase,
    input wire logic        array_program_space
);
    logic [1:0] key_r;
    logic [7:0] ctl_r, dl_r, dh_r, al_r, ah_r, pr_r;
    // Start decode against the shadowed key order and write enable.
    wire go_req = reg_write && reg_addr == NVM_OFS_CONTROL && reg_wdata[NVM_CTL_WRITE_START];
    wire armed  = key_r == 2'h2 && ctl_r[NVM_CTL_WRITE_ENABLE];
    wire k_hit  = reg_write && reg_addr == NVM_OFS_UNLOCK_KEY;
    // Any write other than a key breaks the key order.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            {key_r, ctl_r, dl_r, dh_r, al_r, ah_r} <= '0;
            pr_r <= 8'h03;
        end else if (reg_write) begin
            key_r <= !k_hit ? 2'h0 : reg_wdata == NVM_KEY_FIRST ? 2'h1 :
                     (reg_wdata == NVM_KEY_SECOND && key_r == 2'h1) ? 2'h2 : 2'h0;
            case (reg_addr)
                NVM_OFS_DATA_LOW:     dl_r <= reg_wdata;
                NVM_OFS_DATA_HIGH:    dh_r <= reg_wdata;
                NVM_OFS_ADDRESS_LOW:  al_r <= reg_wdata;
                NVM_OFS_ADDRESS_HIGH: ah_r <= reg_wdata;
                NVM_OFS_CONTROL:      ctl_r <= reg_wdata;
                NVM_OFS_PROTECT:      pr_r <= reg_wdata;
                default:              ;
            endcase
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_go;
        go_req && armed && !cpu_stall_r && !instr_squash_r;
    endsequence
    property p_data_high;
        reg_read && reg_addr == NVM_OFS_DATA_HIGH |=> reg_rdata == {2'h0, dh_r[5:0]};
    endproperty
    a_data_high: assert property (p_data_high) else $error("data high readback wrong");
    property p_addr_high;
        reg_read && reg_addr == NVM_OFS_ADDRESS_HIGH |=> reg_rdata == {1'h1, ah_r[6:0]};
    endproperty
    a_addr_high: assert property (p_addr_high) else $error("address high readback wrong");
    property p_refused;
        go_req && !armed |=> !latch_load_r && !instr_squash_r;
    endproperty
    a_refused: assert property (p_refused) else $error("start taken without keys");
    property p_program;
        s_go ##0 (reg_wdata[NVM_CTL_MEMORY_SELECT] && !reg_wdata[NVM_CTL_LATCH_ONLY]) |=>
            latch_load_r && cpu_stall_r ##1 array_start && !array_erase && array_program_space;
    endproperty
    a_program: assert property (p_program) else $error("row program did not start");
    property p_latch_only;
        s_go ##0 (reg_wdata[NVM_CTL_LATCH_ONLY] || !reg_wdata[NVM_CTL_MEMORY_SELECT]) |=>
            instr_squash_r && !cpu_stall_r ##1 !array_start [*3];
    endproperty
    a_latch_only: assert property (p_latch_only) else $error("latch load ran the array");
    property p_capture;
        latch_load_r |-> latch_index_r == al_r[2:0] && latch_word_r == {dh_r[5:0], dl_r}
            && array_address_r == {ah_r[6:0], al_r};
    endproperty
    a_capture: assert property (p_capture) else $error("latched word or address wrong");
    property p_hold;
        cpu_stall_r && !array_ready && !$past(array_ready) |=> cpu_stall_r;
    endproperty
    a_hold: assert property (p_hold) else $error("stall dropped before array done");
    property p_erase;
        reg_write && reg_addr == NVM_OFS_PROTECT && (reg_wdata[1:0] & ~pr_r[1:0]) != 2'h0
            |-> ##[1:4] (array_start && array_erase);
    endproperty
    a_erase: assert property (p_erase) else $error("unprotect did not erase");
endmodule : nvm_rwa_asserts

bind nvm_row_write_access nvm_rwa_asserts u_chk (
    .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .cpu_stall_r, .instr_squash_r, .latch_load_r, .latch_index_r, .latch_word_r,
    .array_address_r, .array_ready, .array_start, .array_erase, .array_program_space
);

/* File: verification/nvm_flash_model.sv */
// Purpose: Behavioural flash and EEPROM arrays with row write latches.
// Assumes: One operation at a time; delay sets the self-timed length.
// Notes:   Counters let the bench see which operations ran.
`timescale 1ns/10ps
module nvm_flash_model
    import nvm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  delay,
    input  wire logic        latch_load_r,
    input  wire logic [2:0]  latch_index_r,
    input  wire logic [13:0] latch_word_r,
    input  wire logic        array_start,
    input  wire logic        array_erase,
    input  wire logic        array_program_space,
    output logic             array_ready
);
    logic [13:0] latch_mem [NVM_ROW_WORDS];
    logic [4:0]  wait_r;
    logic        busy_r;
    int          rows = 0;
    int          erase_prog = 0;
    int          erase_data = 0;
    // Latches fill word by word; a start counts down, then ready pulses once.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'h0;
            array_ready <= 1'h0;
        end else begin
            array_ready <= 1'h0;
            if (latch_load_r) latch_mem[latch_index_r] <= latch_word_r;
            if (array_start) begin
                busy_r <= 1'h1;
                wait_r <= delay;
                if (!array_erase) rows <= rows + 1;
                else if (array_program_space) erase_prog <= erase_prog + 1;
                else erase_data <= erase_data + 1;
            end else if (busy_r && wait_r == 5'h00) begin
                busy_r <= 1'h0;
                array_ready <= 1'h1;
            end else if (busy_r) wait_r <= wait_r - 5'h01;
        end
    end
endmodule : nvm_flash_model

/* File: verification/nvm_row_write_access_tb.sv */
// Purpose: Self-checking bench for the row write unit.
// Assumes: Register strobes are driven just after a rising edge.
// Notes:   Instruction steps pulse every third cycle.
`timescale 1ns/10ps
module nvm_row_write_access_tb
    import nvm_pkg::*;
;
    logic        sys_clk, resetn, reg_write, reg_read;
    logic        instr_step = 1'h0;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [4:0]  delay;
    logic [31:0] seed;
    wire  [7:0]  reg_rdata;
    wire  [2:0]  latch_index_r;
    wire  [13:0] latch_word_r;
    wire  [14:0] array_address_r;
    wire         cpu_stall_r, instr_squash_r, latch_load_r, array_config_space_r;
    wire         array_ready, array_start, array_erase, array_program_space;
    int          fails, num_checks;
    int          cyc = 0;
    nvm_row_write_access dut (
        .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .instr_step, .cpu_stall_r, .instr_squash_r, .latch_load_r, .latch_index_r,
        .latch_word_r, .array_address_r, .array_config_space_r, .array_ready,
        .array_start, .array_erase, .array_program_space
    );
    nvm_flash_model u_model (
        .sys_clk, .resetn, .delay, .latch_load_r, .latch_index_r, .latch_word_r,
        .array_start, .array_erase, .array_program_space, .array_ready
    );
    // Free-running clock.
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Cycle count paces instruction steps and cuts a hang short.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        instr_step <= (cyc % 3) == 0;
        if (cyc == 60000) begin
            fails++;
            print_verdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // Readback of a holding register after writing d to it.
    function automatic logic [7:0] exp_reg(input logic [2:0] a, input logic [7:0] d);
        return (a == NVM_OFS_DATA_HIGH) ? {2'h0, d[5:0]} :
               (a == NVM_OFS_ADDRESS_HIGH) ? {1'h1, d[6:0]} : d;
    endfunction : exp_reg
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge sys_clk);
        reg_write <= 1'h0;
    endtask : wr
    task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge sys_clk);
        reg_read <= 1'h0;
        #1;
        chk({8'h00, reg_rdata & m}, {8'h00, e});
    endtask : rdchk
    // Enable first, then both keys back to back, then the start write.
    task automatic go(input logic [7:0] ctl);
        wr(NVM_OFS_CONTROL, ctl & 8'hFD);
        wr(NVM_OFS_UNLOCK_KEY, NVM_KEY_FIRST);
        wr(NVM_OFS_UNLOCK_KEY, NVM_KEY_SECOND);
        wr(NVM_OFS_CONTROL, ctl);
    endtask : go
    // Waits for the unit to go idle, counting steps swallowed meanwhile.
    task automatic wait_idle(output int n);
        n = 0;
        for (int i = 0; i < 300; i++) begin
            #1;
            if (instr_squash_r === 1'h1 && instr_step === 1'h1) n++;
            if (cpu_stall_r === 1'h0 && instr_squash_r === 1'h0) return;
            @(posedge sys_clk);
        end
        fails++;
    endtask : wait_idle
    task automatic print_verdict();
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // Main sequence.
    initial begin
        logic [13:0] w [8];
        logic [7:0]  base;
        logic [6:0]  ah;
        int          n, r0;
        {resetn, reg_write, reg_read, reg_addr, reg_wdata, delay} = '0;
        {fails, num_checks} = '0;
        seed = 32'h7B1E3CA8;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'h1;
        rdchk(NVM_OFS_ADDRESS_LOW, 8'h00, 8'hFF);
        rdchk(NVM_OFS_ADDRESS_HIGH, 8'h80, 8'hFF);
        rdchk(NVM_OFS_PROTECT, {6'h00, NVM_PROTECT_RST}, 8'hFF);
        wr(3'h7, 8'hFF);
        rdchk(3'h7, 8'h00, 8'hFF);
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            wr(3'(i % 4), seed[7:0]);
            rdchk(3'(i % 4), exp_reg(3'(i % 4), seed[7:0]), 8'hFF);
        end
        // Keys in the wrong order, then a start without prior enable.
        wr(NVM_OFS_CONTROL, 8'h84);
        wr(NVM_OFS_UNLOCK_KEY, NVM_KEY_SECOND);
        wr(NVM_OFS_UNLOCK_KEY, NVM_KEY_FIRST);
        wr(NVM_OFS_CONTROL, 8'hA6);
        rdchk(NVM_OFS_CONTROL, 8'h00, 8'h02);
        rdchk(NVM_OFS_UNLOCK_KEY, 8'h00, 8'hFF);
        wr(NVM_OFS_CONTROL, 8'hA0);
        wr(NVM_OFS_UNLOCK_KEY, NVM_KEY_FIRST);
        wr(NVM_OFS_UNLOCK_KEY, NVM_KEY_SECOND);
        wr(NVM_OFS_CONTROL, 8'hA6);
        rdchk(NVM_OFS_CONTROL, 8'h00, 8'h02);
        // Two flash rows, one with a prompt array and one with a slow one.
        for (int r = 0; r < 2; r++) begin
            seed = xs(seed);
            base = seed[7:0] & 8'hF8;
            delay <= r ? 5'h1F : 5'h00;
            r0 = u_model.rows;
            ah = seed[14:8];
            wr(NVM_OFS_ADDRESS_HIGH, {1'h0, ah});
            for (int i = 0; i < NVM_ROW_WORDS; i++) begin
                seed = xs(seed);
                w[i] = seed[13:0];
                wr(NVM_OFS_DATA_LOW, seed[7:0]);
                wr(NVM_OFS_DATA_HIGH, {2'h0, seed[13:8]});
                wr(NVM_OFS_ADDRESS_LOW, base | 8'(i));
                go((i == 7) ? 8'h86 : 8'hA6);
                wait_idle(n);
                if (i < 7) chk(16'(n), 16'h0002);
                chk({1'h0, array_address_r}, {1'h0, ah, base | 8'(i)});
                chk(16'(array_config_space_r), 16'h0000);
            end
            for (int i = 0; i < NVM_ROW_WORDS; i++) chk({2'h0, u_model.latch_mem[i]}, {2'h0, w[i]});
            chk(16'(u_model.rows), 16'(r0 + 1));
            rdchk(NVM_OFS_CONTROL, 8'h00, 8'h02);
        end
        // Data memory start in config space captures address, space and latch word, with no latch load or array write.
        r0 = u_model.rows;
        go(8'h46);
        wait_idle(n);
        chk(16'(u_model.rows), 16'(r0));
        chk(16'(array_config_space_r), 16'h0001);
        // Protect both, then lift data and then program protection.
        wr(NVM_OFS_PROTECT, 8'h00);
        wr(NVM_OFS_PROTECT, 8'h02);
        for (int i = 0; i < 100 && (i < 5 || u_model.busy_r !== 1'h0); i++) @(posedge sys_clk);
        wr(NVM_OFS_PROTECT, 8'h03);
        for (int i = 0; i < 100 && (i < 5 || u_model.busy_r !== 1'h0); i++) @(posedge sys_clk);
        // Guard data again with program open, then lift it: only the EEPROM erases.
        wr(NVM_OFS_PROTECT, 8'h01);
        wr(NVM_OFS_PROTECT, 8'h03);
        for (int i = 0; i < 100 && (i < 5 || u_model.busy_r !== 1'h0); i++) @(posedge sys_clk);
        chk(16'(u_model.erase_data), 16'h0002);
        chk(16'(u_model.erase_prog), 16'h0001);
        print_verdict();
    end
endmodule : nvm_row_write_access_tb
